//--- onspe_exec.sv
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
// Function
// - idle_instruction changes no register, memory or flag; only spends its cycles
// - OR sets each result bit if either operand bit set; result to destination
// - OR leaves the source location unchanged for every source mode
// - after OR, zero flag equals result zero, sign flag equals result bit 7
// - after OR, overflow cleared; carry, decimal-adjust, half-carry keep values
// - system pop reads byte at stack pointer into destination, then increments pointer
// - idle, system pop and decrementing user pop leave all flags unchanged
// - user_stack_read_decrement copies byte addressed by user pointer register to destination
// - user_stack_read_decrement decrements the user pointer register after the read
module onspe_exec (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             busy
);
	onspe_pkg::onspe_state_t state;
	onspe_pkg::onspe_dec_t   dec;
	onspe_pkg::onspe_dec_t   next_dec;
	logic [3:0]              cyc_cnt;
	logic [7:0]              ptr_val;
	logic [7:0]              dst_addr;
	logic [7:0]              src_val;
	logic [7:0]              flags;
	logic [15:0]             sp;
	logic [7:0]              rf_addr;
	logic                    illegal;
	logic [7:0]              mem_ra;
	logic [7:0]              mem_rd;
	logic                    mem_we;
	logic [7:0]              mem_wa;
	logic [7:0]              mem_wd;
	logic                    setup;
	logic                    wr_acc;
	logic                    go;
	logic                    idle;
	logic [7:0]              or_res;
	logic [3:0]              run_len;

	assign setup    = psel && !penable;
	assign wr_acc   = psel && penable && pwrite;
	assign idle     = state == onspe_pkg::ST_IDLE;
	// an instruction write while busy is dropped, not queued
	assign go       = wr_acc && paddr == onspe_pkg::ADDR_INSTR && idle;
	assign next_dec = onspe_pkg::decode(pwdata[7:0], pwdata[15:8], pwdata[23:16]);
	assign or_res   = src_val | mem_rd;

	onspe_regfile #(
		.AW (8),
		.DW (8)
	) u_regfile (
		.pclk    (pclk),
		.rd_addr (mem_ra),
		.rd_data (mem_rd),
		.wr_en   (mem_we),
		.wr_addr (mem_wa),
		.wr_data (mem_wd)
	);

	// sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= onspe_pkg::ST_IDLE;
			cyc_cnt <= 4'h0;
			busy    <= 1'b0;
		end else begin
			case (state)
				onspe_pkg::ST_IDLE: begin
					cyc_cnt <= 4'h0;
					if (go && next_dec.legal) begin
						busy <= 1'b1;
						if (next_dec.kind == onspe_pkg::K_NOP) begin
							state <= onspe_pkg::ST_PAD;
						end else if (next_dec.src_mode == onspe_pkg::SRC_IND ||
							next_dec.dst_ind) begin
							state <= onspe_pkg::ST_PTR;
						end else begin
							state <= onspe_pkg::ST_SRC;
						end
					end
				end
				onspe_pkg::ST_PTR: begin
					cyc_cnt <= cyc_cnt + 4'h1;
					state   <= onspe_pkg::ST_SRC;
				end
				onspe_pkg::ST_SRC: begin
					cyc_cnt <= cyc_cnt + 4'h1;
					state   <= onspe_pkg::ST_DST;
				end
				onspe_pkg::ST_DST: begin
					cyc_cnt <= cyc_cnt + 4'h1;
					state   <= onspe_pkg::ST_WB;
				end
				onspe_pkg::ST_WB: begin
					cyc_cnt <= cyc_cnt + 4'h1;
					state   <= (dec.kind == onspe_pkg::K_USER_STACK_READ_DECREMENT) ? onspe_pkg::ST_PTRW
						: onspe_pkg::ST_PAD;
				end
				onspe_pkg::ST_PTRW: begin
					cyc_cnt <= cyc_cnt + 4'h1;
					state   <= onspe_pkg::ST_PAD;
				end
				onspe_pkg::ST_PAD: begin
					cyc_cnt <= cyc_cnt + 4'h1;
					if (cyc_cnt == dec.cycles - 4'h1) begin
						state <= onspe_pkg::ST_IDLE;
						busy  <= 1'b0;
					end
				end
				default: begin
					state <= onspe_pkg::ST_IDLE;
					busy  <= 1'b0;
				end
			endcase
		end
	end

	// decoded instruction and illegal-opcode flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec     <= '0;
			illegal <= 1'b0;
		end else if (go) begin
			illegal <= !next_dec.legal;
			if (next_dec.legal) begin
				dec <= next_dec;
			end
		end
	end

	// operand capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_val  <= 8'h00;
			dst_addr <= 8'h00;
			src_val  <= 8'h00;
		end else begin
			if (go) begin
				dst_addr <= next_dec.dst_addr;
			end
			if (state == onspe_pkg::ST_SRC) begin
				ptr_val <= mem_rd;
				if (dec.dst_ind) begin
					dst_addr <= mem_rd;
				end
			end
			if (state == onspe_pkg::ST_DST) begin
				src_val <= (dec.src_mode == onspe_pkg::SRC_IMM) ? dec.imm : mem_rd;
			end
		end
	end

	// read port: the sequencer owns it in the pointer, source and destination states, software otherwise
	always_comb begin
		case (state)
			onspe_pkg::ST_PTR: mem_ra = dec.ind_addr;
			onspe_pkg::ST_SRC: begin
				if (dec.src_mode == onspe_pkg::SRC_IND) begin
					mem_ra = mem_rd;
				end else if (dec.src_mode == onspe_pkg::SRC_SP) begin
					mem_ra = sp[7:0];
				end else begin
					mem_ra = dec.src_addr;
				end
			end
			onspe_pkg::ST_DST: mem_ra = dst_addr;
			default: mem_ra = rf_addr;
		endcase
	end

	// write port: the sequencer writes only the destination and the user pointer; software writes at rf_addr while idle
	always_comb begin
		mem_we = 1'b0;
		mem_wa = rf_addr;
		mem_wd = pwdata[7:0];
		if (state == onspe_pkg::ST_WB) begin
			mem_we = 1'b1;
			mem_wa = dst_addr;
			mem_wd = (dec.kind == onspe_pkg::K_OR) ? or_res : src_val;
		end else if (state == onspe_pkg::ST_PTRW) begin
			mem_we = 1'b1;
			mem_wa = dec.ind_addr;
			mem_wd = ptr_val - 8'h01;
		end else if (wr_acc && paddr == onspe_pkg::ADDR_RF_DATA && idle) begin
			mem_we = 1'b1;
		end
	end

	// condition flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= onspe_pkg::FLAGS_RST;
		end else if (state == onspe_pkg::ST_WB && dec.kind == onspe_pkg::K_OR) begin
			flags[onspe_pkg::FLAG_Z] <= or_res == 8'h00;
			flags[onspe_pkg::FLAG_S] <= or_res[7];
			flags[onspe_pkg::FLAG_V] <= 1'b0;
		end else if (wr_acc && paddr == onspe_pkg::ADDR_FLAGS && idle) begin
			flags <= {2'b00, pwdata[5:0]};
		end
	end

	// system stack pointer: increment at the same edge that writes the byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp <= onspe_pkg::SP_RST;
		end else if (state == onspe_pkg::ST_WB && dec.kind == onspe_pkg::K_POP) begin
			sp <= sp + 16'h0001;
		end else if (wr_acc && paddr == onspe_pkg::ADDR_SP && idle) begin
			sp <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rf_addr <= onspe_pkg::RF_ADDR_RST;
		end else if (wr_acc && paddr == onspe_pkg::ADDR_RF_ADDR) begin
			rf_addr <= pwdata[7:0];
		end
	end

	// apb answer: zero wait, read data sampled in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				pslverr <= !onspe_pkg::mapped(paddr);
				case (paddr)
					onspe_pkg::ADDR_STATUS: prdata <= {30'h0, illegal, busy};
					onspe_pkg::ADDR_FLAGS: prdata <= {24'h00_0000, flags};
					onspe_pkg::ADDR_SP: prdata <= {16'h0000, sp};
					onspe_pkg::ADDR_RF_ADDR: prdata <= {24'h00_0000, rf_addr};
					onspe_pkg::ADDR_RF_DATA: prdata <= {24'h00_0000, mem_rd};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// helper: length of each run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_len <= 4'h0;
		end else if (!busy) begin
			run_len <= 4'h0;
		end else begin
			run_len <= run_len + 4'h1;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_user_stack_read_decrement_read;
		state == onspe_pkg::ST_DST && dec.kind == onspe_pkg::K_USER_STACK_READ_DECREMENT;
	endsequence

	sequence s_user_stack_read_decrement_ptr_write;
		mem_we && mem_wa == dec.ind_addr && mem_wd == ptr_val - 8'h01;
	endsequence

	a_idle_no_write: assert property (
		(busy && dec.kind == onspe_pkg::K_NOP) |-> !mem_we && $stable(sp))
		else $error("idle instruction wrote state");

	a_or_dest_write: assert property (
		(state == onspe_pkg::ST_DST && dec.kind == onspe_pkg::K_OR)
		##1 1'b1 |-> mem_we && mem_wa == $past(mem_ra) && (mem_wd & src_val) == src_val)
		else $error("or result not written to destination");

	a_or_src_kept: assert property (
		(busy && dec.kind == onspe_pkg::K_OR && mem_we) |-> mem_wa == dst_addr)
		else $error("or wrote outside destination");

	a_or_zero_sign: assert property (
		(state == onspe_pkg::ST_WB && dec.kind == onspe_pkg::K_OR)
		|=> flags[onspe_pkg::FLAG_Z] == ($past(mem_wd) == 8'h00)
		&& flags[onspe_pkg::FLAG_S] == $past(mem_wd[7]))
		else $error("or zero or sign flag wrong");

	a_or_v_cdh: assert property (
		(state == onspe_pkg::ST_WB && dec.kind == onspe_pkg::K_OR)
		|=> !flags[onspe_pkg::FLAG_V] && flags[onspe_pkg::FLAG_C] == $past(flags[onspe_pkg::FLAG_C])
		&& flags[onspe_pkg::FLAG_D] == $past(flags[onspe_pkg::FLAG_D])
		&& flags[onspe_pkg::FLAG_H] == $past(flags[onspe_pkg::FLAG_H]))
		else $error("or overflow or kept flags wrong");

	a_pop_sp_after: assert property (
		(state == onspe_pkg::ST_WB && dec.kind == onspe_pkg::K_POP)
		|-> mem_we && mem_wd == src_val ##1 sp == $past(sp) + 16'h0001)
		else $error("system pop order or increment wrong");

	a_flags_kept: assert property (
		(busy && dec.kind != onspe_pkg::K_OR) |=> flags == $past(flags))
		else $error("flags changed by non-or instruction");

	a_user_stack_read_decrement_copy: assert property (
		s_user_stack_read_decrement_read ##1 1'b1 |-> mem_we && mem_wd == $past(mem_rd) && mem_wa == dst_addr)
		else $error("user pop copied wrong byte");

	a_user_stack_read_decrement_dec: assert property (
		s_user_stack_read_decrement_read |-> ##2 s_user_stack_read_decrement_ptr_write)
		else $error("user pointer not decremented after read");

	a_decode_user_stack_read_decrement: assert property (
		(go && pwdata[7:0] == onspe_pkg::OPC_USER_STACK_READ_DECREMENT)
		|=> busy && dec.kind == onspe_pkg::K_USER_STACK_READ_DECREMENT && dec.cycles == onspe_pkg::CYC_POP)
		else $error("user pop opcode misdecoded");

	a_cycle_count: assert property (
		$fell(busy) |-> $past(run_len) == $past(dec.cycles) - 4'h1)
		else $error("instruction length wrong");

endmodule // onspe_exec

//--- onspe_pkg.sv
package onspe_pkg;

	// opcodes
	localparam logic [7:0] OPC_IDLE  = 8'hFF;
	localparam logic [7:0] OPC_OR_WR = 8'h42;
	localparam logic [7:0] OPC_OR_WI = 8'h43;
	localparam logic [7:0] OPC_OR_RR = 8'h44;
	localparam logic [7:0] OPC_OR_RI = 8'h45;
	localparam logic [7:0] OPC_OR_IM = 8'h46;
	localparam logic [7:0] OPC_POP_R = 8'h50;
	localparam logic [7:0] OPC_POP_I = 8'h51;
	localparam logic [7:0] OPC_USER_STACK_READ_DECREMENT = 8'h92;

	// execution lengths in core cycles
	localparam logic [3:0] CYC_IDLE  = 4'h4;
	localparam logic [3:0] CYC_OR_WR = 4'h4;
	localparam logic [3:0] CYC_OR_WI = 4'h6;
	localparam logic [3:0] CYC_OR_R  = 4'h6;
	localparam logic [3:0] CYC_POP   = 4'h8;

	// register map, byte addresses
	localparam logic [11:0] ADDR_INSTR   = 12'h0000;
	localparam logic [11:0] ADDR_STATUS  = 12'h0004;
	localparam logic [11:0] ADDR_FLAGS   = 12'h0008;
	localparam logic [11:0] ADDR_SP      = 12'h000C;
	localparam logic [11:0] ADDR_RF_ADDR = 12'h0010;
	localparam logic [11:0] ADDR_RF_DATA = 12'h0014;

	// flag bit positions
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_S = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_D = 4;
	localparam int unsigned FLAG_H = 5;

	// status bit positions
	localparam int unsigned STAT_BUSY    = 0;
	localparam int unsigned STAT_ILLEGAL = 1;

	// reset values and working-register base
	localparam logic [7:0]  FLAGS_RST   = 8'h00;
	localparam logic [15:0] SP_RST      = 16'h0000;
	localparam logic [7:0]  RF_ADDR_RST = 8'h00;
	localparam logic [7:0]  WR_BASE     = 8'hC0;

	typedef enum logic [1:0] {
		K_NOP   = 2'b00,
		K_OR    = 2'b01,
		K_POP   = 2'b10,
		K_USER_STACK_READ_DECREMENT = 2'b11
	} onspe_kind_t;

	typedef enum logic [1:0] {
		SRC_REG = 2'b00,
		SRC_IND = 2'b01,
		SRC_IMM = 2'b10,
		SRC_SP  = 2'b11
	} onspe_src_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PTR  = 3'b001,
		ST_SRC  = 3'b010,
		ST_DST  = 3'b011,
		ST_WB   = 3'b100,
		ST_PTRW = 3'b101,
		ST_PAD  = 3'b110
	} onspe_state_t;

	typedef struct packed {
		logic        legal;
		onspe_kind_t kind;
		onspe_src_t  src_mode;
		logic        dst_ind;
		logic [3:0]  cycles;
		logic [7:0]  src_addr;
		logic [7:0]  dst_addr;
		logic [7:0]  ind_addr;
		logic [7:0]  imm;
	} onspe_dec_t;

	function automatic onspe_dec_t decode(input logic [7:0] opc, input logic [7:0] op1,
		input logic [7:0] op2);
		onspe_dec_t d;
		d = '{legal: 1'b1, kind: K_NOP, src_mode: SRC_REG, dst_ind: 1'b0, cycles: CYC_IDLE,
			src_addr: op1, dst_addr: op2, ind_addr: op1, imm: op2};
		case (opc)
			OPC_IDLE: d.kind = K_NOP;
			OPC_OR_WR, OPC_OR_WI: begin
				d.kind     = K_OR;
				d.dst_addr = WR_BASE | {4'h0, op1[7:4]};
				d.src_addr = WR_BASE | {4'h0, op1[3:0]};
				d.ind_addr = d.src_addr;
				d.src_mode = (opc == OPC_OR_WI) ? SRC_IND : SRC_REG;
				d.cycles   = (opc == OPC_OR_WI) ? CYC_OR_WI : CYC_OR_WR;
			end
			OPC_OR_RR, OPC_OR_RI: begin
				d.kind     = K_OR;
				d.src_mode = (opc == OPC_OR_RI) ? SRC_IND : SRC_REG;
				d.cycles   = CYC_OR_R;
			end
			OPC_OR_IM: begin
				d.kind     = K_OR;
				d.src_mode = SRC_IMM;
				d.dst_addr = op1;
				d.cycles   = CYC_OR_R;
			end
			OPC_POP_R, OPC_POP_I: begin
				d.kind     = K_POP;
				d.src_mode = SRC_SP;
				d.dst_addr = op1;
				d.dst_ind  = (opc == OPC_POP_I);
				d.cycles   = CYC_POP;
			end
			OPC_USER_STACK_READ_DECREMENT: begin
				d.kind     = K_USER_STACK_READ_DECREMENT;
				d.src_mode = SRC_IND;
				d.cycles   = CYC_POP;
			end
			default: d.legal = 1'b0;
		endcase
		return d;
	endfunction

	function automatic logic mapped(input logic [11:0] addr);
		return addr == ADDR_INSTR || addr == ADDR_STATUS || addr == ADDR_FLAGS ||
			addr == ADDR_SP || addr == ADDR_RF_ADDR || addr == ADDR_RF_DATA;
	endfunction

endpackage

//--- onspe_regfile.sv
`timescale 1ns/1ps
module onspe_regfile #(
	parameter int unsigned AW = 8,
	parameter int unsigned DW = 8
) (
	input  wire logic          pclk,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	initial begin
		if (AW < 1 || AW > 16 || DW < 1) begin
			$error("onspe_regfile: unsupported size");
		end
	end

	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// write-first so a read in the write cycle sees the new byte
	always_ff @(posedge pclk) begin
		if (wr_en && wr_addr == rd_addr) begin
			rd_data <= wr_data;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule // onspe_regfile

//--- tb_or_nop_stack_pop_exec.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_or_nop_stack_pop_exec;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [7:0]  rf [256];
	logic [7:0]  flags;
	logic [15:0] sp;
	int          mismatches, total_checks, cycles, n;
	logic [7:0]  ops [9] = '{8'hff, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h50, 8'h51, 8'h92};

	onspe_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .busy(busy));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// generous ceiling: whole run needs about 4200 cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			stop_test();
		end
	end

	function automatic void nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// request held until pready seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the bench timeout ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic set_rf(input logic [7:0] a, input logic [7:0] v);
		apb(1'b1, onspe_pkg::ADDR_RF_ADDR, {24'h0, a});
		apb(1'b1, onspe_pkg::ADDR_RF_DATA, {24'h0, v});
		rf[a] = v;
	endtask

	task automatic chk_rf(input logic [7:0] a);
		apb(1'b1, onspe_pkg::ADDR_RF_ADDR, {24'h0, a});
		apb(1'b0, onspe_pkg::ADDR_RF_DATA, 32'h0);
		`CHK(rd, {24'h0, rf[a]})
	endtask

	// busy counted from the launching edge, sampled after updates land
	task automatic wait_idle();
		#1 n = 0;
		while (busy === 1'b1 && n < 40) begin
			@(posedge pclk);
			#1 n++;
		end
	endtask

	task automatic exec(input logic [7:0] opc, input logic [7:0] b1, input logic [7:0] b2);
		logic [7:0] d, a, src, r;
		int         want;
		d = b2;
		a = b1;
		want = 6;
		src = rf[b1];
		case (opc)
			8'hff: want = 4;
			8'h42, 8'h43: begin
				d = 8'hc0 | {4'h0, b1[7:4]};
				a = 8'hc0 | {4'h0, b1[3:0]};
				want = opc[0] ? 6 : 4;
				src = opc[0] ? rf[rf[a]] : rf[a];
			end
			8'h44, 8'h45: src = opc[0] ? rf[rf[b1]] : rf[b1];
			8'h46: begin
				d = b1;
				src = b2;
			end
			8'h50, 8'h51: begin
				d = opc[0] ? rf[b1] : b1;
				a = sp[7:0];
				want = 8;
			end
			8'h92: begin
				a = rf[b1];
				want = 8;
			end
			default: want = 0;
		endcase
		apb(1'b1, onspe_pkg::ADDR_INSTR, {8'h00, b2, b1, opc});
		wait_idle();
		`CHK(n, want)
		if (opc[7:4] == 4'h4) begin
			r = rf[d] | src;
			rf[d] = r;
			flags[onspe_pkg::FLAG_Z] = (r == 8'h00);
			flags[onspe_pkg::FLAG_S] = r[7];
			flags[onspe_pkg::FLAG_V] = 1'b0;
		end else if (opc[7:4] == 4'h5) begin
			rf[d] = rf[a];
			sp = sp + 16'h0001;
		end else if (opc == 8'h92) begin
			rf[b2] = rf[a];
			// decrement is of the pointer read first, and lands after the copy
			rf[b1] = a - 8'h01;
		end
		chk_rf(d);
		chk_rf(a);
		chk_rf(b1);
		chk_rf(b2);
		apb(1'b0, onspe_pkg::ADDR_FLAGS, 32'h0);
		`CHK(rd, {24'h0, flags})
		apb(1'b0, onspe_pkg::ADDR_SP, 32'h0);
		`CHK(rd, {16'h0, sp})
	endtask

	initial begin
		seed = 32'h0000_65c9;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (10) @(posedge pclk);
		`CHK({pready, pslverr, busy, prdata}, 35'h0)
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, onspe_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h0)
		`CHK(pready, 1'b1)
		apb(1'b0, onspe_pkg::ADDR_FLAGS, 32'h0);
		`CHK(rd, {24'h0, onspe_pkg::FLAGS_RST})
		apb(1'b0, onspe_pkg::ADDR_SP, 32'h0);
		`CHK(rd, {16'h0, onspe_pkg::SP_RST})
		apb(1'b0, onspe_pkg::ADDR_RF_ADDR, 32'h0);
		`CHK(rd, {24'h0, onspe_pkg::RF_ADDR_RST})
		apb(1'b0, 12'h018, 32'h0);
		`CHK({err, rd}, 33'h1_0000_0000)
		apb(1'b1, 12'h020, 32'hffff_ffff);
		`CHK(err, 1'b1)
		flags = 8'h00;
		sp = 16'h0000;
		// register file is not reset, so load every byte once
		for (int i = 0; i < 256; i++) begin
			nxt();
			set_rf(i[7:0], seed[7:0]);
		end
		apb(1'b1, onspe_pkg::ADDR_FLAGS, 32'h0000_003f);
		flags = 8'h3f;
		set_rf(8'h10, 8'h00);
		exec(8'h46, 8'h10, 8'h00);
		exec(8'h46, 8'h10, 8'h80);
		apb(1'b1, onspe_pkg::ADDR_SP, 32'h0000_00ff);
		sp = 16'h00ff;
		exec(8'h50, 8'h11, 8'h00);
		set_rf(8'h12, 8'h00);
		exec(8'h92, 8'h12, 8'h13);
		for (int k = 0; k < 6; k++) begin
			for (int j = 0; j < 9; j++) begin
				nxt();
				apb(1'b1, onspe_pkg::ADDR_FLAGS, {26'h0, seed[5:0]});
				flags = {2'b00, seed[5:0]};
				apb(1'b1, onspe_pkg::ADDR_SP, {16'h0, seed[31:16]});
				sp = seed[31:16];
				nxt();
				exec(ops[j], seed[7:0], seed[15:8]);
			end
		end
		apb(1'b1, onspe_pkg::ADDR_INSTR, 32'h0000_0000);
		#1;
		`CHK(busy, 1'b0)
		apb(1'b0, onspe_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h0000_0002)
		// flag write lands while the idle instruction runs and must be dropped
		apb(1'b1, onspe_pkg::ADDR_INSTR, 32'h0000_00ff);
		apb(1'b1, onspe_pkg::ADDR_FLAGS, {24'h0, ~flags & 8'h3f});
		wait_idle();
		apb(1'b0, onspe_pkg::ADDR_FLAGS, 32'h0);
		`CHK(rd, {24'h0, flags})
		stop_test();
	end
endmodule // tb_or_nop_stack_pop_exec
